/* File: src/recorder_serial_port_defs.svh */
// constant macros for the recorder serial port
`ifndef RECORDER_SERIAL_PORT_DEFS_SVH
`define RECORDER_SERIAL_PORT_DEFS_SVH

`define RSP_CLK_HZ 100000000
`define RSP_BAUD 38400
`define RSP_BIT_CYCLES (`RSP_CLK_HZ / `RSP_BAUD)
`define RSP_DATA_BITS 8
`define RSP_STOP_BITS 1
`define RSP_FIFO_DEPTH 8
`define RSP_CTRL_RESET_N_INIT 1'b0
`define RSP_CTRL_FAN_INIT 1'b0

`endif

/* File: src/recorder_serial_port_pkg.sv */
// types shared by the recorder serial port files
package recorder_serial_port_pkg;
	// transmitter states
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_STOP
	} tx_state_e;
	// receiver states
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rx_state_e;
	// received character with its status
	typedef struct packed {
		logic frame_err;
		logic [7:0] data;
	} rx_char_s;
	// software controls of the recorder pins
	typedef struct packed {
		logic reset_n;
		logic fan_on;
	} ctrl_s;
endpackage : recorder_serial_port_pkg

/* File: src/rsp_fifo.sv */
// parameterised valid/ready fifo
`timescale 1ns/100ps
`default_nettype none
module rsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];  // storage
	logic [AW:0] wr_ptr_q;  // write pointer with wrap bit
	logic [AW:0] rd_ptr_q;  // read pointer with wrap bit
	logic push;
	logic pop;
	assign wr_ready_out = (wr_ptr_q - rd_ptr_q) != (AW + 1)'(DEPTH);
	assign rd_valid_out = wr_ptr_q != rd_ptr_q;
	assign rd_data_out = mem_q[rd_ptr_q[AW-1:0]];
	assign push = wr_valid_in && wr_ready_out;
	assign pop = rd_valid_out && rd_ready_in;
	// write side
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_q <= '0;
		end else if (push) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end
	// storage has no reset
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
		end
	end
	// read side
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_ptr_q <= '0;
		end else if (pop) begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end
endmodule : rsp_fifo
`default_nettype wire

/* File: src/rsp_sync.sv */
// two flop synchroniser for a level
`timescale 1ns/100ps
`default_nettype none
module rsp_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic d_in,
	output logic q_out
);
	logic meta_q;  // first stage, read only by the second
	// two stages
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= INIT;
			q_out <= INIT;
		end else begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule : rsp_sync
`default_nettype wire

/* File: src/recorder_serial_port.sv */
// serial port toward a strip-chart recorder
`timescale 1ns/100ps
`default_nettype none
`include "recorder_serial_port_defs.svh"
// Overview of operation
// [R01] frames: 8 data, no parity, 1 stop
// [R02] bit rate 38.4K from system clock
// [R03] start character only while CTS asserted
// [R04] next command waits for recorder done
// [R05] host sends commands then data bytes
// [R06] recorder turns commands into print data
// [R07] reset output low set by software bit
// [R08] active-low ready line raises interrupt event
// [R09] software bit switches fan on/off
// [R10] fan status sampled, shown to software
// [R11] low stop bit flags error, drops character
// [R12] outputs idle inactive after reset; PRINTER_RESET_N_OUT is the exception, it resets low (asserted)
module recorder_serial_port
	import recorder_serial_port_pkg::*;
#(
	parameter int BIT_CYCLES = `RSP_BIT_CYCLES,
	parameter int FIFO_DEPTH = `RSP_FIFO_DEPTH
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] TX_DATA_IN,  // byte from the host channel
	input wire logic TX_VALID_IN,
	output logic TX_READY_OUT,
	input wire logic TX_CMD_END_IN,  // marks last byte of a command
	output logic [7:0] RX_DATA_OUT,
	output logic RX_VALID_OUT,  // one-cycle pulse
	output logic FRAME_ERR_OUT,  // one-cycle pulse
	input wire logic CTRL_WR_IN,  // write strobe for control bits
	input wire logic CTRL_RESET_N_IN,
	input wire logic CTRL_FAN_ON_IN,
	input wire logic RTS_EN_IN,  // software asks to receive
	output logic FAN_STATUS_OUT,
	output logic READY_EVENT_OUT,  // one-cycle pulse
	output logic CMD_BUSY_OUT,
	output logic TXD_OUT,
	input wire logic RXD_IN,
	output logic RTS_N_OUT,
	input wire logic CTS_N_IN,
	output logic PRINTER_RESET_N_OUT,
	input wire logic PRINTER_READY_IRQ_N_IN,
	output logic FAN_ON_OUT,
	input wire logic FAN_STATUS_IN
);
	// bit timer width and its two terminal counts
	localparam int CW = $clog2(BIT_CYCLES + 1);
	localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
	// refuse settings that the counters cannot serve
	initial begin
		if (BIT_CYCLES < 4) $error("bit period too short");
		if (FIFO_DEPTH < 2) $error("fifo too shallow");
	end

	// synchronised inputs
	logic rxd_s;
	logic cts_n_s;
	logic ready_n_s;
	logic fan_s;
	rsp_sync #(.INIT(1'b1)) u_sync_rxd (.clk_in(CLK_IN), .rst_in(RST_IN), .d_in(RXD_IN), .q_out(rxd_s));
	rsp_sync #(.INIT(1'b1)) u_sync_cts (.clk_in(CLK_IN), .rst_in(RST_IN), .d_in(CTS_N_IN), .q_out(cts_n_s));
	rsp_sync #(.INIT(1'b1)) u_sync_rdy (.clk_in(CLK_IN), .rst_in(RST_IN),
		.d_in(PRINTER_READY_IRQ_N_IN), .q_out(ready_n_s));
	rsp_sync #(.INIT(1'b0)) u_sync_fan (.clk_in(CLK_IN), .rst_in(RST_IN), .d_in(FAN_STATUS_IN), .q_out(fan_s));

	// control register
	ctrl_s ctrl_q;
	// software bits drive reset and fan pins
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ctrl_q.reset_n <= `RSP_CTRL_RESET_N_INIT;  // [R12]
			ctrl_q.fan_on <= `RSP_CTRL_FAN_INIT;
		end else if (CTRL_WR_IN) begin
			ctrl_q.reset_n <= CTRL_RESET_N_IN;  // [R07]
			ctrl_q.fan_on <= CTRL_FAN_ON_IN;  // [R09]
		end
	end
	// both pins come straight from flip-flops
	assign PRINTER_RESET_N_OUT = ctrl_q.reset_n;  // [R07]
	assign FAN_ON_OUT = ctrl_q.fan_on;  // [R09]

	// fan status exposed as a registered level
	// two sync flops plus this register give three cycles of lag
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			FAN_STATUS_OUT <= 1'b0;
		end else begin
			FAN_STATUS_OUT <= fan_s;  // [R10]
		end
	end

	// ready line falling edge becomes an event
	// the detector idles high like the pin, so reset makes no false edge
	logic ready_n_d1_q;
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ready_n_d1_q <= 1'b1;
			READY_EVENT_OUT <= 1'b0;
		end else begin
			ready_n_d1_q <= ready_n_s;
			READY_EVENT_OUT <= ready_n_d1_q && !ready_n_s;  // [R08]
		end
	end

	// transmit fifo, carries a command-end flag with each byte
	// a full fifo holds the host off through TX_READY_OUT
	logic [8:0] fifo_rd_data;
	logic fifo_rd_valid;
	logic fifo_rd_ready;
	rsp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.wr_data_in({TX_CMD_END_IN, TX_DATA_IN}),  // [R05]
		.wr_valid_in(TX_VALID_IN),
		.wr_ready_out(TX_READY_OUT),
		.rd_data_out(fifo_rd_data),
		.rd_valid_out(fifo_rd_valid),
		.rd_ready_in(fifo_rd_ready)
	);

	// command busy: set by last byte sent, cleared by recorder ready
	logic cmd_busy_q;
	logic cmd_done_set;  // last byte of a command left the shifter
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cmd_busy_q <= 1'b0;
		end else if (cmd_done_set) begin
			cmd_busy_q <= 1'b1;  // set wins over clear
		end else if (READY_EVENT_OUT) begin
			cmd_busy_q <= 1'b0;  // [R04]
		end
	end
	assign CMD_BUSY_OUT = cmd_busy_q;

	// transmitter
	tx_state_e tx_state_q;
	logic [CW-1:0] tx_cnt_q;  // cycles within a bit
	logic [2:0] tx_bit_q;  // data bit index
	logic [7:0] tx_shift_q;
	logic tx_last_q;  // byte ends a command
	logic tx_tick;
	logic tx_start;
	assign tx_tick = tx_cnt_q == BIT_LAST;  // [R02]
	// a character leaves the fifo only with cts low and no command pending
	assign tx_start = tx_state_q == TX_IDLE && fifo_rd_valid && !cts_n_s && !cmd_busy_q;  // [R03] [R04]
	assign fifo_rd_ready = tx_start;
	// busy rises as the stop bit of a command's last byte ends
	assign cmd_done_set = tx_state_q == TX_STOP && tx_tick && tx_last_q;

	// bit timer
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tx_cnt_q <= '0;
		end else if (tx_state_q == TX_IDLE || tx_tick) begin
			tx_cnt_q <= '0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 1'b1;
		end
	end

	// frame sequencer
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tx_state_q <= TX_IDLE;
			tx_bit_q <= '0;
			tx_shift_q <= '0;
			tx_last_q <= 1'b0;
			TXD_OUT <= 1'b1;  // [R12]
		end else begin
			case (tx_state_q)
				TX_IDLE: begin
					TXD_OUT <= 1'b1;
					if (tx_start) begin
						tx_shift_q <= fifo_rd_data[7:0];
						tx_last_q <= fifo_rd_data[8];
						TXD_OUT <= 1'b0;  // start bit
						tx_state_q <= TX_START;
					end
				end
				TX_START: begin
					if (tx_tick) begin
						TXD_OUT <= tx_shift_q[0];  // lsb first [R01]
						tx_shift_q <= {1'b0, tx_shift_q[7:1]};
						tx_bit_q <= '0;
						tx_state_q <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_tick) begin
						if (tx_bit_q == 3'(`RSP_DATA_BITS - 1)) begin
							TXD_OUT <= 1'b1;  // single stop, no parity [R01]
							tx_state_q <= TX_STOP;
						end else begin
							TXD_OUT <= tx_shift_q[0];
							tx_shift_q <= {1'b0, tx_shift_q[7:1]};
							tx_bit_q <= tx_bit_q + 1'b1;
						end
					end
				end
				TX_STOP: begin
					if (tx_tick) begin
						tx_state_q <= TX_IDLE;
					end
				end
				default: begin
					tx_state_q <= TX_IDLE;
					TXD_OUT <= 1'b1;
				end
			endcase
		end
	end

	// rts: asserted low only when software enables receive
	// a plain level, registered so the pin never glitches
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			RTS_N_OUT <= 1'b1;  // [R12]
		end else begin
			RTS_N_OUT <= !RTS_EN_IN;  // [R03]
		end
	end

	// receiver
	rx_state_e rx_state_q;
	logic [CW-1:0] rx_cnt_q;
	logic [2:0] rx_bit_q;
	rx_char_s rx_q;  // last good byte and the status of the last frame
	logic [7:0] rx_shift_q;  // byte being gathered, lsb first
	logic rx_tick;
	assign rx_tick = (rx_state_q == RX_START) ? (rx_cnt_q == HALF_LAST) : (rx_cnt_q == BIT_LAST);

	// receive bit timer, half bit into start then full bits
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rx_cnt_q <= '0;
		end else if (rx_state_q == RX_IDLE || rx_tick) begin
			rx_cnt_q <= '0;
		end else begin
			rx_cnt_q <= rx_cnt_q + 1'b1;
		end
	end

	// receive sequencer
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rx_state_q <= RX_IDLE;
			rx_bit_q <= '0;
			rx_q <= '0;
			rx_shift_q <= '0;
			RX_VALID_OUT <= 1'b0;
			FRAME_ERR_OUT <= 1'b0;
		end else begin
			RX_VALID_OUT <= 1'b0;
			FRAME_ERR_OUT <= 1'b0;
			case (rx_state_q)
				RX_IDLE: begin
					// a low line may open a start bit
					if (!rxd_s) begin
						rx_state_q <= RX_START;
					end
				end
				RX_START: begin
					if (rx_tick) begin
						// glitch shorter than half a bit is ignored
						rx_state_q <= rxd_s ? RX_IDLE : RX_DATA;
						rx_bit_q <= '0;
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_shift_q <= {rxd_s, rx_shift_q[7:1]};  // [R01]
						rx_bit_q <= rx_bit_q + 1'b1;
						if (rx_bit_q == 3'(`RSP_DATA_BITS - 1)) begin
							rx_state_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_tick) begin
						rx_q.frame_err <= !rxd_s;
						// a low stop bit drops the byte, the output keeps the last good one
						if (rxd_s) begin
							rx_q.data <= rx_shift_q;  // [R11]
						end
						RX_VALID_OUT <= rxd_s;  // [R11]
						FRAME_ERR_OUT <= !rxd_s;  // [R11]
						rx_state_q <= RX_IDLE;
					end
				end
				default: begin
					rx_state_q <= RX_IDLE;
				end
			endcase
		end
	end
	assign RX_DATA_OUT = rx_q.data;
endmodule : recorder_serial_port
`default_nettype wire

/* File: test/recorder_serial_port_properties.sv */
// concurrent checks on the recorder serial port pins
`timescale 1ns/100ps
`default_nettype none
module recorder_serial_port_properties #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic CTRL_WR_IN,
	input wire logic CTRL_RESET_N_IN,
	input wire logic CTRL_FAN_ON_IN,
	input wire logic RTS_EN_IN,
	input wire logic RTS_N_OUT,
	input wire logic TXD_OUT,
	input wire logic CTS_N_IN,
	input wire logic CMD_BUSY_OUT,
	input wire logic PRINTER_RESET_N_OUT,
	input wire logic FAN_ON_OUT,
	input wire logic PRINTER_READY_IRQ_N_IN,
	input wire logic READY_EVENT_OUT
);
	logic [15:0] left_q; // cycles left in the outgoing frame
	logic frame_start; // line falls while no frame runs
	assign frame_start = left_q == 16'h0000 && !TXD_OUT;
	// frame tracker, lets us find start and stop bits
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			left_q <= 16'h0000;
		end else if (frame_start) begin
			left_q <= 16'(10 * BIT_CYCLES - 1);
		end else if (left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence ready_fall;
		$fell(PRINTER_READY_IRQ_N_IN);
	endsequence
	sequence event_pulse;
		READY_EVENT_OUT ##1 !READY_EVENT_OUT;
	endsequence
	idle_after_reset_a: assert property ($fell(RST_IN) |-> TXD_OUT && RTS_N_OUT && !PRINTER_RESET_N_OUT && !FAN_ON_OUT)
		else $error("pins not idle after reset");
	ctrl_load_a: assert property (CTRL_WR_IN |=> PRINTER_RESET_N_OUT == $past(CTRL_RESET_N_IN))
		else $error("reset pin not loaded");
	fan_load_a: assert property (CTRL_WR_IN |=> FAN_ON_OUT == $past(CTRL_FAN_ON_IN))
		else $error("fan pin not loaded");
	ctrl_hold_a: assert property (!CTRL_WR_IN |=> $stable(PRINTER_RESET_N_OUT) && $stable(FAN_ON_OUT))
		else $error("control pins moved without write");
	rts_follow_a: assert property (1'b1 |=> RTS_N_OUT == !$past(RTS_EN_IN))
		else $error("rts pin wrong");
	start_on_cts_a: assert property (frame_start |-> !$past(CTS_N_IN, 3))
		else $error("frame started without cts");
	start_not_busy_a: assert property (frame_start |-> !$past(CMD_BUSY_OUT))
		else $error("frame started while busy");
	start_bit_low_a: assert property (left_q == 16'(10 * BIT_CYCLES - BIT_CYCLES / 2) |-> !TXD_OUT)
		else $error("start bit not low");
	stop_bit_high_a: assert property (left_q == 16'(BIT_CYCLES / 2) |-> TXD_OUT)
		else $error("stop bit not high");
	ready_event_a: assert property (ready_fall |-> ##[2:5] event_pulse)
		else $error("ready event missing");
	busy_clear_a: assert property (READY_EVENT_OUT && left_q == 16'h0000 |=> !CMD_BUSY_OUT)
		else $error("busy not cleared");
endmodule : recorder_serial_port_properties
bind recorder_serial_port recorder_serial_port_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
	.CLK_IN(CLK_IN),
	.RST_IN(RST_IN),
	.CTRL_WR_IN(CTRL_WR_IN),
	.CTRL_RESET_N_IN(CTRL_RESET_N_IN),
	.CTRL_FAN_ON_IN(CTRL_FAN_ON_IN),
	.RTS_EN_IN(RTS_EN_IN),
	.RTS_N_OUT(RTS_N_OUT),
	.TXD_OUT(TXD_OUT),
	.CTS_N_IN(CTS_N_IN),
	.CMD_BUSY_OUT(CMD_BUSY_OUT),
	.PRINTER_RESET_N_OUT(PRINTER_RESET_N_OUT),
	.FAN_ON_OUT(FAN_ON_OUT),
	.PRINTER_READY_IRQ_N_IN(PRINTER_READY_IRQ_N_IN),
	.READY_EVENT_OUT(READY_EVENT_OUT)
);
`default_nettype wire

/* File: test/printer_model.sv */
// behavioural recorder on the far side of the link
`timescale 1ns/100ps
`default_nettype none
module printer_model #(
	parameter int BC = 16
) (
	input wire logic clk_in,
	input wire logic txd_in,
	input wire logic fan_on_in,
	output logic cts_n_out,
	output logic rdy_n_out,
	output logic fan_st_out,
	output logic rxd_out
);
	logic [7:0] got[$]; // bytes taken from the line
	logic stall = 1'b0; // holds off the sender
	logic [7:0] sh; // byte being gathered
	initial begin
		cts_n_out = 1'b0;
		rdy_n_out = 1'b1;
		rxd_out = 1'b1;
	end
	// clear to send follows the stall request
	always @(posedge clk_in) cts_n_out <= stall;
	// fan reports running when switched on
	assign fan_st_out = fan_on_in;
	// catch frames mid bit, lsb first, drop bad stop
	always begin
		@(negedge txd_in);
		repeat (BC / 2) @(posedge clk_in);
		for (int i = 0; i < 9; i++) begin
			repeat (BC) @(posedge clk_in);
			if (i < 8) sh[i] = txd_in;
		end
		if (txd_in) got.push_back(sh);
	end
	// send one frame, stop level chosen by caller
	task automatic send(input logic [7:0] d, input logic stp);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_in);
			rxd_out <= f[i];
			repeat (BC - 1) @(posedge clk_in);
		end
		@(posedge clk_in);
		rxd_out <= 1'b1;
	endtask : send
	// command done, pull ready low a few cycles
	task automatic ready();
		@(posedge clk_in);
		rdy_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		rdy_n_out <= 1'b1;
	endtask : ready
endmodule : printer_model
`default_nettype wire

/* File: test/recorder_serial_port_test.sv */
// self-checking bench for the recorder serial port
`timescale 1ns/100ps
`default_nettype none
module recorder_serial_port_test;
	logic CLK_IN = 1'b0;
	logic RST_IN = 1'b1;
	logic TX_VALID_IN = 1'b0;
	logic TX_CMD_END_IN = 1'b0;
	logic CTRL_WR_IN = 1'b0;
	logic CTRL_RESET_N_IN = 1'b0;
	logic CTRL_FAN_ON_IN = 1'b0;
	logic RTS_EN_IN = 1'b0;
	logic [7:0] TX_DATA_IN = 8'h00;
	logic [7:0] RX_DATA_OUT;
	logic TX_READY_OUT, RX_VALID_OUT, FRAME_ERR_OUT, FAN_STATUS_OUT, READY_EVENT_OUT, CMD_BUSY_OUT;
	logic TXD_OUT, RTS_N_OUT, PRINTER_RESET_N_OUT, FAN_ON_OUT;
	wire logic RXD_IN, CTS_N_IN, PRINTER_READY_IRQ_N_IN, FAN_STATUS_IN;
	int fails = 0; // mismatches seen
	int comparisons = 0; // checks made
	// 100 MHz clock
	always #5 CLK_IN = ~CLK_IN;
	// design with a short bit time
	recorder_serial_port #(.BIT_CYCLES(16), .FIFO_DEPTH(8)) u_dut (
		.CLK_IN(CLK_IN),
		.RST_IN(RST_IN),
		.TX_DATA_IN(TX_DATA_IN),
		.TX_VALID_IN(TX_VALID_IN),
		.TX_READY_OUT(TX_READY_OUT),
		.TX_CMD_END_IN(TX_CMD_END_IN),
		.RX_DATA_OUT(RX_DATA_OUT),
		.RX_VALID_OUT(RX_VALID_OUT),
		.FRAME_ERR_OUT(FRAME_ERR_OUT),
		.CTRL_WR_IN(CTRL_WR_IN),
		.CTRL_RESET_N_IN(CTRL_RESET_N_IN),
		.CTRL_FAN_ON_IN(CTRL_FAN_ON_IN),
		.RTS_EN_IN(RTS_EN_IN),
		.FAN_STATUS_OUT(FAN_STATUS_OUT),
		.READY_EVENT_OUT(READY_EVENT_OUT),
		.CMD_BUSY_OUT(CMD_BUSY_OUT),
		.TXD_OUT(TXD_OUT),
		.RXD_IN(RXD_IN),
		.RTS_N_OUT(RTS_N_OUT),
		.CTS_N_IN(CTS_N_IN),
		.PRINTER_RESET_N_OUT(PRINTER_RESET_N_OUT),
		.PRINTER_READY_IRQ_N_IN(PRINTER_READY_IRQ_N_IN),
		.FAN_ON_OUT(FAN_ON_OUT),
		.FAN_STATUS_IN(FAN_STATUS_IN)
	);
	// recorder on the far side
	printer_model #(.BC(16)) u_rec (.clk_in(CLK_IN), .txd_in(TXD_OUT), .fan_on_in(FAN_ON_OUT),
		.cts_n_out(CTS_N_IN), .rdy_n_out(PRINTER_READY_IRQ_N_IN), .fan_st_out(FAN_STATUS_IN), .rxd_out(RXD_IN));
	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// a wait that ran out ends the run
	task automatic limit(input int n, input int top);
		if (n >= top) begin
			fails++;
			conclude();
		end
	endtask : limit
	task automatic wait_got(input int k);
		int n;
		for (n = 0; n < 3000 && u_rec.got.size() < k; n++) @(posedge CLK_IN);
		limit(n, 3000);
	endtask : wait_got
	// offer a byte just after an edge, hold until taken
	task automatic put(input logic [7:0] d, input logic last);
		int n;
		TX_DATA_IN <= d;
		TX_VALID_IN <= 1'b1;
		TX_CMD_END_IN <= last;
		for (n = 0; n < 3000; n++) begin
			#1;
			if (TX_READY_OUT === 1'b1) break;
			@(posedge CLK_IN);
		end
		limit(n, 3000);
		@(posedge CLK_IN);
	endtask : put
	task automatic t_reset();
		#1;
		check({TXD_OUT, RTS_N_OUT, PRINTER_RESET_N_OUT, FAN_ON_OUT, TX_READY_OUT, CMD_BUSY_OUT,
			FAN_STATUS_OUT, READY_EVENT_OUT}, 8'hC8);
	endtask : t_reset
	task automatic ctrl(input logic rn, input logic fan);
		@(posedge CLK_IN);
		CTRL_WR_IN <= 1'b1;
		CTRL_RESET_N_IN <= rn;
		CTRL_FAN_ON_IN <= fan;
		@(posedge CLK_IN);
		CTRL_WR_IN <= 1'b0;
		repeat (4) @(posedge CLK_IN);
		#1;
		check(8'(PRINTER_RESET_N_OUT), 8'(rn));
		check(8'(FAN_ON_OUT), 8'(fan));
		check(8'(FAN_STATUS_OUT), 8'(fan));
	endtask : ctrl
	task automatic t_rts();
		@(posedge CLK_IN);
		RTS_EN_IN <= 1'b1;
		repeat (2) @(posedge CLK_IN);
		#1;
		check(8'(RTS_N_OUT), 8'h00);
	endtask : t_rts
	// command of two bytes, then a byte held back until ready
	task automatic t_cmd();
		@(posedge CLK_IN);
		put(8'hA5, 1'b0);
		put(8'h3C, 1'b1);
		TX_VALID_IN <= 1'b0;
		wait_got(2);
		check(u_rec.got[0], 8'hA5);
		check(u_rec.got[1], 8'h3C);
		repeat (20) @(posedge CLK_IN);
		#1;
		check(8'(CMD_BUSY_OUT), 8'h01);
		@(posedge CLK_IN);
		put(8'h5A, 1'b0);
		TX_VALID_IN <= 1'b0;
		repeat (300) @(posedge CLK_IN);
		check(8'(u_rec.got.size()), 8'h02);
		u_rec.ready();
		wait_got(3);
		#1;
		check(u_rec.got[2], 8'h5A);
		check(8'(CMD_BUSY_OUT), 8'h00);
	endtask : t_cmd
	// fill the buffer while cts stalls, then drain it
	task automatic t_fifo();
		u_rec.got.delete();
		u_rec.stall = 1'b1;
		repeat (200) @(posedge CLK_IN);
		for (int i = 0; i < 8; i++) put(8'(i * 17), i == 7);
		#1;
		check(8'(TX_READY_OUT), 8'h00);
		@(posedge CLK_IN);
		TX_VALID_IN <= 1'b0;
		repeat (50) @(posedge CLK_IN);
		check(8'(u_rec.got.size()), 8'h00);
		u_rec.stall = 1'b0;
		wait_got(8);
		for (int i = 0; i < 8; i++) check(u_rec.got[i], 8'(i * 17));
		repeat (20) @(posedge CLK_IN);
		#1;
		check(8'(CMD_BUSY_OUT), 8'h01);
		u_rec.ready();
		repeat (10) @(posedge CLK_IN);
		#1;
		check(8'(CMD_BUSY_OUT), 8'h00);
	endtask : t_fifo
	// one received frame, good or with a low stop bit
	task automatic t_rx(input logic [7:0] d, input logic stp, input logic [7:0] keep);
		logic v;
		logic e;
		v = 1'b0;
		e = 1'b0;
		fork
			u_rec.send(d, stp);
		join_none
		for (int n = 0; n < 200; n++) begin
			@(posedge CLK_IN);
			#1;
			v = v | RX_VALID_OUT;
			e = e | FRAME_ERR_OUT;
		end
		check(8'(v), 8'(stp));
		check(8'(e), 8'(!stp));
		if (stp) check(RX_DATA_OUT, d);
		else check(RX_DATA_OUT, keep);
	endtask : t_rx
	// reset in mid-run puts every pin back to its reset level, printer reset low
	task automatic t_mid_reset();
		@(posedge CLK_IN);
		RST_IN <= 1'b1;
		repeat (5) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		t_reset();
	endtask : t_mid_reset
	initial begin
		repeat (5) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		t_reset();
		ctrl(1'b1, 1'b0);
		ctrl(1'b0, 1'b1);
		ctrl(1'b1, 1'b1);
		t_rts();
		t_cmd();
		t_fifo();
		t_rx(8'h96, 1'b1, 8'h00);
		t_rx(8'h3B, 1'b0, 8'h96);
		t_mid_reset();
		ctrl(1'b1, 1'b0);
		conclude();
	end
endmodule : recorder_serial_port_test
`default_nettype wire
